// file: rtl/pairable_timers_params.svh
// Offsets, field positions, reset values and prescale counts of the timer block
`ifndef PAIRABLE_TIMERS_PARAMS_SVH
`define PAIRABLE_TIMERS_PARAMS_SVH

`define TMR_COUNT 9
`define ADR_W 8

// Per-timer window: timer n (0 = standalone, 1..8 = paired) at n*0x10
`define OFS_CTRL 4'h0
`define OFS_COUNT 4'h4
`define OFS_PERIOD 4'h8
`define OFS_IRQ_FLAG 8'h90
`define OFS_IRQ_EN 8'h94
`define OFS_IRQ_PRIO 8'h98

// Control field positions
`define BIT_RUN 15
`define BIT_IDLE_STOP 13
`define BIT_GATE 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_PAIR 3
`define BIT_SYNC 2
`define BIT_CLKSRC 1

// Implemented control bits per timer kind
`define CTRL_MASK_SOLO 16'hA076
`define CTRL_MASK_EVEN 16'hA07A
`define CTRL_MASK_ODD 16'hA072

// Reset values
`define CTRL_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'hFFFF

// Prescaler terminal counts (divide ratio minus one)
`define PS_TERM_1 8'h00
`define PS_TERM_8 8'h07
`define PS_TERM_64 8'h3F
`define PS_TERM_256 8'hFF

`endif

// file: rtl/pairable_timers_pkg.sv
// Types shared by the pairable timer block
package pairable_timers_pkg;

  typedef logic [15:0] word16_t;

  typedef enum logic [1:0] {
    PS_DIV1,
    PS_DIV8,
    PS_DIV64,
    PS_DIV256
  } prescale_t;

  typedef logic [7:0] prescale_cnt_t;

endpackage : pairable_timers_pkg

// file: rtl/pairable_interval_timers.sv
// Standalone timer plus eight pairable 16/32-bit timers behind a Wishbone slave
// How it works
// [R1] Standalone 16-bit timer, sync or async counter
// [R2] Standalone irq on period match or gate fall
// [R3] Run bit 15 starts and stops counting
// [R4] Idle-stop bit 13 halts timer in Idle
// [R5] Gate bit 6 only with internal clock
// [R6] Prescale bits 5-4: 1, 8, 64, 256
// [R7] Sync bit 2 syncs external clock, standalone
// [R8] Clock source bit 1 selects external pin
// [R9] Unimplemented standalone control bits read zero
// [R10] Pairs: two 16-bit or one 32-bit
// [R11] Even timer low word, odd high word
// [R12] Pair mode uses only even timer's controls
// [R13] Pair irq appears on odd timer flag
// [R14] Odd period high, even period low half
// [R15] Count pair readable, odd holds high word
// [R16] Pair irq when 32-bit count matches period
// [R17] Software sets pair bit first, run last
// [R18] Software clears pair bit, run last
// [R19] Only timers two/three give time base
// [R20] Pairs 2/3 and 4/5 trigger converters
// [R21] Timers may run in Idle and Sleep; in Sleep only the async standalone counter runs
// [R22] Even control bit 3 joins the pair
// [R23] Software clears idle-stop for idle pairs
// [R24] Match resets count next tick, sets flag
// [R25] Gated: count only while gate high
`timescale 1ns/1ns
`default_nettype none
`include "pairable_timers_params.svh"

module pairable_interval_timers
  import pairable_timers_pkg::*;
#(
  parameter int NUM_TIMERS = `TMR_COUNT
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Device power state
  input wire logic idle_i,
  input wire logic sleep_i,
  // External count / gate pins, one per timer
  input wire logic [NUM_TIMERS-1:0] external_count_pin_i,
  // Interrupt requests and priorities
  output logic [NUM_TIMERS-1:0] timer_irq_o,
  output logic [3*NUM_TIMERS-1:0] timer_irq_priority_o,
  // Capture/compare time base and converter triggers
  output pairable_timers_pkg::word16_t timebase_a_o,
  output pairable_timers_pkg::word16_t timebase_b_o,
  output logic conv1_trigger_o,
  output logic conv2_trigger_o
);

  import pairable_timers_pkg::*;

  localparam int N = NUM_TIMERS;

  word16_t ctrl_ff [N];
  word16_t cnt_ff [N];
  word16_t per_ff [N];
  prescale_cnt_t pre_ff [N];
  prescale_cnt_t nxt_pre [N];
  word16_t nxt_cnt [N];
  logic [N-1:0] flag_ff;
  logic [N-1:0] irq_en_ff;
  logic [3*N-1:0] irq_prio_ff;
  logic [N-1:0] set_flag;
  logic [N-1:0] tick;
  logic [N-1:0] match16;
  logic [N-1:0] gate_fall;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic conv1_ff;
  logic conv2_ff;
  logic nxt_conv1;
  logic nxt_conv2;

  // Pin synchronisers: three stages, level moves only when stages 2 and 3 agree
  logic [N-1:0] pin_s1_ff;
  logic [N-1:0] pin_s2_ff;
  logic [N-1:0] pin_s3_ff;
  logic [N-1:0] pin_lvl_ff;
  logic [N-1:0] pin_prev_ff;
  logic [N-1:0] pin_rise;
  logic [N-1:0] pin_fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
      pin_lvl_ff <= '0;
      pin_prev_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= external_count_pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_lvl_ff <= (pin_s2_ff & pin_s3_ff) | (pin_lvl_ff & (pin_s2_ff | pin_s3_ff));
      pin_prev_ff <= pin_lvl_ff;
    end
  end

  // Rising edge of the pin counts in external mode
  assign pin_rise = pin_lvl_ff & ~pin_prev_ff; // [R8]
  assign pin_fall = ~pin_lvl_ff & pin_prev_ff;

  // Wishbone decode
  logic req;
  logic wr_en;
  logic [3:0] tmr_sel;
  logic [3:0] reg_sel;
  word16_t wmask;

  assign req = cyc_i & stb_i;
  assign wr_en = req & we_i & ack_ff;
  assign tmr_sel = adr_i[7:4];
  assign reg_sel = adr_i[3:0];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  function automatic word16_t ctrl_mask(input int idx);
    if (idx == 0)
      ctrl_mask = `CTRL_MASK_SOLO;
    else if (idx % 2 == 1)
      ctrl_mask = `CTRL_MASK_EVEN;
    else
      ctrl_mask = `CTRL_MASK_ODD;
  endfunction : ctrl_mask

  function automatic prescale_cnt_t ps_term(input logic [1:0] code);
    case (prescale_t'(code))
      PS_DIV1: ps_term = `PS_TERM_1;
      PS_DIV8: ps_term = `PS_TERM_8;
      PS_DIV64: ps_term = `PS_TERM_64;
      PS_DIV256: ps_term = `PS_TERM_256;
      default: ps_term = `PS_TERM_1;
    endcase
  endfunction : ps_term

  function automatic word16_t merge(input word16_t old, input word16_t wm, input word16_t nw);
    merge = (old & ~wm) | (nw & wm);
  endfunction : merge

  // Upper half of a joined pair takes every control from its even partner
  function automatic int src_of(input int idx, input logic pair_bit);
    if (idx >= 2 && idx % 2 == 0 && pair_bit)
      src_of = idx - 1; // [R12]
    else
      src_of = idx;
  endfunction : src_of

  // Tick generation per timer
  always_comb
  begin
    int s;
    word16_t c;
    logic ext;
    logic async_mode;
    logic run;
    logic gated;
    logic edge_ok;
    s = 0;
    c = '0;
    ext = 1'b0;
    async_mode = 1'b0;
    run = 1'b0;
    gated = 1'b0;
    edge_ok = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      s = (i >= 2) ? src_of(i, ctrl_ff[i-1][`BIT_PAIR]) : i;
      c = ctrl_ff[s];
      ext = c[`BIT_CLKSRC];
      // Unsynchronised counting exists only on the standalone timer
      async_mode = (s == 0) & ext & ~c[`BIT_SYNC]; // [R7] [R1] [R10]
      // Instruction clock is gone in Sleep; only the async counter keeps going
      run = c[`BIT_RUN] & ~(idle_i & c[`BIT_IDLE_STOP]) & ~(sleep_i & ~async_mode); // [R3] [R4] [R21]
      gated = ~ext & c[`BIT_GATE]; // [R5]
      edge_ok = ext ? pin_rise[s] : (gated ? pin_lvl_ff[s] : 1'b1); // [R8] [R25]
      gate_fall[i] = run & gated & pin_fall[s]; // [R2]
      tick[i] = 1'b0;
      nxt_pre[i] = pre_ff[i];
      if (!run)
        nxt_pre[i] = '0;
      else if (edge_ok)
      begin
        if (pre_ff[i] == ps_term(c[`BIT_PS_HI:`BIT_PS_LO])) // [R6]
        begin
          nxt_pre[i] = '0;
          tick[i] = 1'b1;
        end
        else
          nxt_pre[i] = pre_ff[i] + 8'h01;
      end
    end
  end

  // Count and flag updates, 16-bit first, then joined pairs override
  logic [N/2-1:0] pair_evt;
  always_comb
  begin
    int lo;
    int hi;
    logic [31:0] cnt32;
    logic [31:0] per32;
    lo = 0;
    hi = 0;
    cnt32 = '0;
    per32 = '0;
    pair_evt = '0;
    for (int i = 0; i < N; i++)
    begin
      match16[i] = (cnt_ff[i] == per_ff[i]);
      nxt_cnt[i] = cnt_ff[i];
      set_flag[i] = gate_fall[i];
      if (tick[i])
      begin
        if (match16[i])
        begin
          nxt_cnt[i] = '0; // [R24]
          set_flag[i] = 1'b1; // [R2] [R24]
        end
        else
          nxt_cnt[i] = cnt_ff[i] + 16'h0001; // [R1]
      end
    end
    for (int p = 0; p < N / 2; p++)
    begin
      lo = 2 * p + 1;
      hi = 2 * p + 2;
      pair_evt[p] = tick[lo] & match16[lo];
      if (ctrl_ff[lo][`BIT_PAIR]) // [R22]
      begin
        cnt32 = {cnt_ff[hi], cnt_ff[lo]}; // [R11]
        per32 = {per_ff[hi], per_ff[lo]}; // [R14]
        pair_evt[p] = tick[lo] & (cnt32 == per32); // [R16]
        nxt_cnt[lo] = cnt_ff[lo];
        nxt_cnt[hi] = cnt_ff[hi];
        if (tick[lo])
        begin
          if (cnt32 == per32)
          begin
            nxt_cnt[lo] = '0;
            nxt_cnt[hi] = '0;
          end
          else
          begin
            cnt32 = cnt32 + 32'h0000_0001;
            nxt_cnt[lo] = cnt32[15:0];
            nxt_cnt[hi] = cnt32[31:16];
          end
        end
        set_flag[lo] = 1'b0;
        set_flag[hi] = pair_evt[p] | gate_fall[lo]; // [R13]
      end
    end
  end

  // Converter triggers from the first two pairs only
  assign nxt_conv1 = pair_evt[0]; // [R20]
  assign nxt_conv2 = pair_evt[1]; // [R20]

  // Timer registers
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (rst_i)
      begin
        ctrl_ff[i] <= `CTRL_RESET;
        cnt_ff[i] <= `COUNT_RESET;
        per_ff[i] <= `PERIOD_RESET;
        pre_ff[i] <= '0;
      end
      else
      begin
        pre_ff[i] <= nxt_pre[i];
        if (wr_en && tmr_sel == 4'(i) && reg_sel == `OFS_CTRL)
          ctrl_ff[i] <= merge(ctrl_ff[i], wmask, dat_i[15:0]) & ctrl_mask(i); // [R9]
        if (wr_en && tmr_sel == 4'(i) && reg_sel == `OFS_PERIOD)
          per_ff[i] <= merge(per_ff[i], wmask, dat_i[15:0]);
        // A software write wins over a tick in the same cycle
        if (wr_en && tmr_sel == 4'(i) && reg_sel == `OFS_COUNT)
          cnt_ff[i] <= merge(cnt_ff[i], wmask, dat_i[15:0]);
        else
          cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  // Interrupt flags: write one to clear, a same-cycle set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_ff <= '0;
    else if (wr_en && adr_i == `OFS_IRQ_FLAG)
      flag_ff <= (flag_ff & ~(dat_i[N-1:0] & {{(N-8){sel_i[1]}}, {8{sel_i[0]}}})) | set_flag;
    else
      flag_ff <= flag_ff | set_flag;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_en_ff <= '0;
      irq_prio_ff <= '0;
    end
    else
    begin
      if (wr_en && adr_i == `OFS_IRQ_EN)
        irq_en_ff <= dat_i[N-1:0];
      if (wr_en && adr_i == `OFS_IRQ_PRIO)
        irq_prio_ff <= dat_i[3*N-1:0];
    end
  end

  // Bus answer: ack one cycle after the request, read data alongside
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff)
      begin
        dat_ff <= '0;
        if (tmr_sel < 4'(N))
        begin
          case (reg_sel)
            `OFS_CTRL: dat_ff <= {16'h0000, ctrl_ff[tmr_sel] & ctrl_mask(int'(tmr_sel))}; // [R9]
            `OFS_COUNT: dat_ff <= {16'h0000, cnt_ff[tmr_sel]}; // [R15]
            `OFS_PERIOD: dat_ff <= {16'h0000, per_ff[tmr_sel]};
            default: dat_ff <= '0;
          endcase
        end
        else if (adr_i == `OFS_IRQ_FLAG)
          dat_ff <= 32'(flag_ff);
        else if (adr_i == `OFS_IRQ_EN)
          dat_ff <= 32'(irq_en_ff);
        else if (adr_i == `OFS_IRQ_PRIO)
          dat_ff <= 32'(irq_prio_ff);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv1_ff <= 1'b0;
      conv2_ff <= 1'b0;
    end
    else
    begin
      conv1_ff <= nxt_conv1;
      conv2_ff <= nxt_conv2;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;
  assign timer_irq_o = flag_ff & irq_en_ff;
  assign timer_irq_priority_o = irq_prio_ff;
  assign timebase_a_o = cnt_ff[1]; // [R19]
  assign timebase_b_o = cnt_ff[2]; // [R19]
  assign conv1_trigger_o = conv1_ff;
  assign conv2_trigger_o = conv2_ff;

endmodule : pairable_interval_timers
`default_nettype wire

// file: dv/pit_sva.sv
// Port checker for the pairable timer block
`timescale 1ns/1ns
`default_nettype none
module pit_chk #(
  parameter int NUM_TIMERS = 9
)
(
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Timer outputs
  input wire logic [NUM_TIMERS-1:0] timer_irq_o,
  input wire logic [3*NUM_TIMERS-1:0] timer_irq_priority_o,
  input wire logic conv1_trigger_o,
  input wire logic conv2_trigger_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_trig_one_pulse: assert property (conv1_trigger_o |=> !conv1_trigger_o)
    else $error("first trigger too long");
  chk_trig_two_pulse: assert property (conv2_trigger_o |=> !conv2_trigger_o)
    else $error("second trigger too long");
  // A write lands on the ack edge, so its effect shows as ack falls
  chk_prio_by_bus: assert property ($changed(timer_irq_priority_o) |-> $fell(ack_o))
    else $error("priority moved without write");
  chk_irq_clear_bus: assert property (($past(timer_irq_o) & ~timer_irq_o) != '0 |-> $fell(ack_o))
    else $error("irq dropped without write");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && timer_irq_o == '0)
    else $error("outputs busy after reset");
endmodule : pit_chk
bind pairable_interval_timers pit_chk #(.NUM_TIMERS(NUM_TIMERS)) chk_u (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .ack_o(ack_o),
  .timer_irq_o(timer_irq_o),
  .timer_irq_priority_o(timer_irq_priority_o),
  .conv1_trigger_o(conv1_trigger_o),
  .conv2_trigger_o(conv2_trigger_o)
);
`default_nettype wire

// file: dv/ext_pin_model.sv
// External count and gate pins driven from outside the device
`timescale 1ns/1ns
`default_nettype none
module ext_pin_model (
  input wire logic clk_i,
  input wire logic burst_i,
  input wire logic [8:0] level_i,
  output logic [8:0] pin_o
);
  logic [2:0] ph_ff;
  always_ff @(posedge clk_i)
  begin
    ph_ff <= burst_i ? ph_ff + 3'h1 : 3'h0;
  end
  // Still between bursts, one rising edge each 8 clocks within
  assign pin_o = level_i | {8'h00, burst_i & ph_ff[2]};
endmodule : ext_pin_model
`default_nettype wire

// file: dv/pairable_interval_timers_bench.sv
// Self-checking bench for the pairable timer block
`timescale 1ns/1ns
`default_nettype none
module pairable_interval_timers_bench;
  import pairable_timers_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic idle_i = 1'b0;
  logic sleep = 1'b0;
  logic burst = 1'b0;
  logic [8:0] lvl = 9'h000;
  logic [8:0] pins;
  logic [8:0] irq;
  word16_t tb_a;
  word16_t tb_b;
  logic [26:0] prio;
  logic c1;
  logic c2;
  logic [31:0] rd;
  int num_errors = 0;
  int cmp_count = 0;
  int n1 = 0;
  int n2 = 0;
  int b1;
  int dv[4] = '{1, 8, 64, 256};
  logic [7:0] ca[3] = '{8'h00, 8'h10, 8'h20};
  logic [31:0] ce[3] = '{32'hA076, 32'hA07A, 32'hA072};
  logic [31:0] ec[4] = '{32'h8006, 32'h8002, 32'h8006, 32'h8002};
  logic [31:0] ex[4] = '{32'h5, 32'h5, 32'h0, 32'h5};
  pairable_interval_timers dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(4'hF),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .idle_i(idle_i),
    .sleep_i(sleep),
    .external_count_pin_i(pins),
    .timer_irq_o(irq),
    .timer_irq_priority_o(prio),
    .timebase_a_o(tb_a),
    .timebase_b_o(tb_b),
    .conv1_trigger_o(c1),
    .conv2_trigger_o(c2)
  );
  ext_pin_model pin_u (
    .clk_i(clk_i),
    .burst_i(burst),
    .level_i(lvl),
    .pin_o(pins)
  );
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    n1 <= n1 + int'(c1);
    n2 <= n2 + int'(c2);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until ack is sampled; read data taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (ack_o !== 1'b1 && t < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (t >= 50)
    begin
      chk("ack", 0, 1);
      tally_and_finish();
    end
  endtask : wb
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h08, 0);
    chk("period", rd, 32'hFFFF);
    foreach (ca[i])
    begin
      wb(1, ca[i], 32'hFFFF);
      wb(0, ca[i], 0);
      chk("ctrl", rd, ce[i]);
      wb(1, ca[i], 0);
    end
    for (int p = 0; p < 4; p++)
    begin
      wb(1, 8'h04, 0);
      wb(1, 8'h00, 32'h8000 | (p << 4));
      repeat (10 * dv[p]) @(posedge clk_i);
      wb(1, 8'h00, 0);
      wb(0, 8'h04, 0);
      b1 = (10 * dv[p] + 2) / dv[p];
      chk("prescale", {31'h0, rd + 1 >= b1 && rd <= b1 + 1}, 1);
    end
    // Count, period, enable, run bit last
    wb(1, 8'h04, 0);
    wb(1, 8'h08, 2);
    wb(1, 8'h94, 1);
    wb(1, 8'h00, 32'h8000);
    repeat (9) @(posedge clk_i);
    wb(1, 8'h00, 0);
    wb(0, 8'h04, 0);
    // Twelve ticks over a three-count period end on zero
    chk("wrap", rd, 0);
    chk("irq", irq[0], 1);
    wb(1, 8'h90, 1);
    idle_i <= 1'b1;
    #1;
    chk("irqclr", irq[0], 0);
    wb(1, 8'h04, 0);
    wb(1, 8'h08, 32'hFFFF);
    wb(1, 8'h00, 32'hA000);
    repeat (20) @(posedge clk_i);
    wb(0, 8'h04, 0);
    chk("idlestop", rd, 0);
    wb(1, 8'h00, 32'h8000);
    repeat (20) @(posedge clk_i);
    wb(0, 8'h04, 0);
    chk("idlerun", {31'h0, rd > 20}, 1);
    wb(1, 8'h00, 0);
    idle_i <= 1'b0;
    // Last two bursts in Sleep: only the unsynchronised counter moves
    foreach (ec[i])
    begin
      sleep <= (i >= 2);
      wb(1, 8'h04, 0);
      wb(1, 8'h00, ec[i]);
      burst <= 1'b1;
      repeat (40) @(posedge clk_i);
      burst <= 1'b0;
      repeat (8) @(posedge clk_i);
      wb(0, 8'h04, 0);
      chk("extcount", rd, ex[i]);
    end
    sleep <= 1'b0;
    wb(1, 8'h90, 32'h1FF);
    wb(1, 8'h04, 0);
    wb(1, 8'h00, 32'h8040);
    repeat (5) @(posedge clk_i);
    lvl[0] <= 1'b1;
    repeat (30) @(posedge clk_i);
    lvl[0] <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(0, 8'h04, 0);
    chk("gated", {31'h0, rd >= 28 && rd <= 32}, 1);
    wb(0, 8'h90, 0);
    chk("gatefall", rd[0], 1);
    wb(1, 8'h00, 0);
    // Pair bit first; odd control asks for 1:256, pair mode must ignore it
    wb(1, 8'h10, 32'h0008);
    wb(1, 8'h90, 32'h1FF);
    wb(1, 8'h94, 32'h6);
    wb(1, 8'h20, 32'h0030);
    wb(1, 8'h18, 3);
    wb(1, 8'h28, 1);
    wb(1, 8'h14, 32'hFFFE);
    wb(1, 8'h24, 0);
    b1 = n1;
    wb(1, 8'h10, 32'h8008);
    repeat (2) @(posedge clk_i);
    wb(1, 8'h10, 32'h0008);
    wb(0, 8'h24, 0);
    chk("highword", rd, 1);
    chk("timebase_b", tb_b, rd[15:0]);
    wb(0, 8'h14, 0);
    chk("lowword", rd, 3);
    chk("timebase", tb_a, rd[15:0]);
    // Idle-stop clear, so the pair keeps counting in Idle
    idle_i <= 1'b1;
    wb(1, 8'h10, 32'h8008);
    repeat (6) @(posedge clk_i);
    wb(1, 8'h10, 32'h0008);
    idle_i <= 1'b0;
    wb(0, 8'h24, 0);
    chk("pairwrap", rd, 0);
    wb(0, 8'h14, 0);
    chk("pairlow", rd, 8);
    wb(0, 8'h90, 0);
    chk("oddflag", rd[2:1], 2'b10);
    chk("pairirq", irq[2:1], 2'b10);
    chk("conv1", n1 - b1, 1);
    chk("conv2", n2, 0);
    wb(1, 8'h98, 32'h1C0);
    #1;
    chk("prio", prio, 32'h1C0);
    tally_and_finish();
  end
endmodule : pairable_interval_timers_bench
`default_nettype wire
